// ### verilog/lit_exec_pkg.sv
// Shared constants, encodings and types for the literal ALU execution block.
`default_nettype none
package lit_exec_pkg;

  // Instruction word width and field positions.
  localparam int          INSTR_W         = 14;
  localparam int          OPC_HI          = 13;
  localparam int          OPC_LO          = 8;
  localparam int          LIT_HI          = 7;
  localparam int          LIT_LO          = 0;
  localparam int          DEST_BIT        = 7;
  localparam int          FADDR_HI        = 6;
  localparam int          FADDR_LO        = 0;

  // Literal opcode patterns in the top six bits; a mask keeps only the bits that matter.
  localparam logic [5:0]  OPC_ADD_PAT     = 6'h3E;
  localparam logic [5:0]  OPC_ADD_MASK    = 6'h3E;
  localparam logic [5:0]  OPC_SUB_PAT     = 6'h3C;
  localparam logic [5:0]  OPC_SUB_MASK    = 6'h3E;
  localparam logic [5:0]  OPC_AND_PAT     = 6'h39;
  localparam logic [5:0]  OPC_XOR_PAT     = 6'h3A;
  localparam logic [5:0]  OPC_FULL_MASK   = 6'h3F;
  // Program-counter changers known from the opcode alone: jumps, calls, literal return.
  localparam logic [5:0]  OPC_JUMP_PAT    = 6'h20;
  localparam logic [5:0]  OPC_JUMP_MASK   = 6'h30;
  localparam logic [5:0]  OPC_RETLIT_PAT  = 6'h34;
  localparam logic [5:0]  OPC_RETLIT_MASK = 6'h3C;
  // File-writing forms: byte ops with destination bit, bit clear and bit set.
  localparam logic [1:0]  OPC_BYTE_GRP    = 2'h0;
  localparam logic [2:0]  OPC_BITSET_GRP  = 3'h2;

  // Register map of the plain software port.
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam logic [7:0]  REG_ACCUM       = 8'h00;
  localparam logic [7:0]  REG_FLAGS       = 8'h04;
  localparam logic [7:0]  REG_CTRL        = 8'h08;
  localparam logic [7:0]  REG_PINS        = 8'h0C;

  // Field positions inside the flags and control registers.
  localparam int          FLAG_C_BIT      = 0;
  localparam int          FLAG_HALF_BIT   = 1;
  localparam int          FLAG_Z_BIT      = 2;
  localparam int          CTRL_PSA_BIT    = 0;

  // Reset values.
  localparam logic [7:0]  ACCUM_RST       = 8'h00;
  localparam logic        FLAG_RST        = 1'b0;
  localparam logic        PSA_RST         = 1'b0;
  localparam logic [7:0]  BYTE_ZERO       = 8'h00;

  // Operation chosen by the literal decoder.
  typedef enum logic [2:0] {
    OP_NONE,
    OP_ADD,
    OP_SUB,
    OP_AND,
    OP_XOR
  } lit_op_t;

  // True when the opcode bits kept by the mask equal the pattern.
  function automatic logic opc_match(input logic [5:0] opc,
                                     input logic [5:0] pat,
                                     input logic [5:0] mask);
    return ((opc & mask) == pat);
  endfunction

  // Decode the top six opcode bits into a literal operation.
  function automatic lit_op_t decode_lit_op(input logic [5:0] opc);
    lit_op_t op;
    op = OP_NONE;
    if (opc_match(opc, OPC_ADD_PAT, OPC_ADD_MASK)) begin
      op = OP_ADD;
    end else if (opc_match(opc, OPC_SUB_PAT, OPC_SUB_MASK)) begin
      op = OP_SUB;
    end else if (opc_match(opc, OPC_AND_PAT, OPC_FULL_MASK)) begin
      op = OP_AND;
    end else if (opc_match(opc, OPC_XOR_PAT, OPC_FULL_MASK)) begin
      op = OP_XOR;
    end
    return op;
  endfunction

endpackage
`default_nettype wire

// ### verilog/lit_alu_if.sv
// Carrier between the execution control and the literal ALU datapath.
`timescale 1ns/1ps
`default_nettype none
interface lit_alu_if;
  import lit_exec_pkg::*;
  lit_op_t     op;          // Operation to perform.
  logic [7:0]  literal;     // Eight-bit literal operand.
  logic [7:0]  acc;         // Current accumulator value.
  logic [7:0]  result;      // Eight-bit result.
  logic        carry;       // Carry out of bit 7, inverted borrow on subtract.
  logic        half_carry;  // Carry out of bit 3.
  logic        zero;        // Result is zero.
  logic        arith;       // Operation updates carry and half carry.

  // Datapath end.
  modport core (input op, literal, acc, output result, carry, half_carry, zero, arith);
  // Control end.
  modport user (output op, literal, acc, input result, carry, half_carry, zero, arith);
endinterface
`default_nettype wire

// ### verilog/lit_alu_core.sv
// Combinational datapath for the literal add, subtract, AND and exclusive OR.
`timescale 1ns/1ps
`default_nettype none
module lit_alu_core (
  lit_alu_if.core  alu
);
  import lit_exec_pkg::*;

  logic [8:0]  sum9;   // Full sum with carry out of bit 7.
  logic [4:0]  sum5;   // Low-nibble sum with carry out of bit 3.
  logic [7:0]  addend; // Accumulator or its complement.
  logic        cin;    // One for two's-complement subtraction.

  // Subtraction is literal plus inverted accumulator plus one, so carry is an inverted borrow.
  always_comb begin
    addend         = alu.acc;
    cin            = 1'b0;
    alu.result     = BYTE_ZERO;
    alu.arith      = 1'b0;
    case (alu.op)
      OP_SUB: begin
        addend    = ~alu.acc;
        cin       = 1'b1;
        alu.arith = 1'b1;
      end
      OP_ADD: begin
        alu.arith = 1'b1;
      end
      default: begin
        alu.arith = 1'b0;
      end
    endcase
    sum9 = {1'b0, alu.literal} + {1'b0, addend} + {8'h00, cin};
    sum5 = {1'b0, alu.literal[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
    case (alu.op)
      OP_ADD:  alu.result = sum9[7:0];
      OP_SUB:  alu.result = sum9[7:0];
      OP_AND:  alu.result = alu.literal & alu.acc;
      OP_XOR:  alu.result = alu.literal ^ alu.acc;
      default: alu.result = alu.acc;
    endcase
    alu.carry      = sum9[8];
    alu.half_carry = sum5[4];
    alu.zero       = (alu.result == BYTE_ZERO);
  end

endmodule
`default_nettype wire

// ### verilog/literal_alu_instruction_exec.sv
// Execution control for literal ALU instructions, two-cycle flushes, prescaler clear and pin reads.
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module literal_alu_instruction_exec #(
  parameter logic [6:0] TIMER_ZERO_ADDR = 7'h01,  // File address of the timer-zero count.
  parameter logic [6:0] PORT_ADDR_FIRST = 7'h05,  // First file address that is an I/O port.
  parameter logic [6:0] PORT_ADDR_LAST  = 7'h09   // Last file address that is an I/O port.
) (
  input  wire  logic                          clock_in,            // Core clock, 200 MHz.
  input  wire  logic                          nrst_in,             // Asynchronous reset, low.
  input  wire  logic                          instr_valid_in,      // Instruction word present.
  input  wire  logic [lit_exec_pkg::INSTR_W-1:0] instr_in,         // Fetched instruction word.
  input  wire  logic                          program_counter_change_in, // Jump or true test.
  input  wire  logic [7:0]                    file_data_in,        // Register file read data.
  input  wire  logic [7:0]                    pin_in,              // Raw port pin levels.
  input  wire  logic [lit_exec_pkg::ADDR_W-1:0] reg_addr_in,       // Software port address.
  input  wire  logic [lit_exec_pkg::DATA_W-1:0] reg_wdata_in,      // Software write data.
  input  wire  logic                          reg_wr_in,           // Software write strobe.
  input  wire  logic                          reg_rd_in,           // Software read strobe.
  output logic       [lit_exec_pkg::DATA_W-1:0] reg_rdata_out,     // Read data, next cycle.
  output logic       [7:0]                    accumulator_out,     // Working accumulator.
  output logic                                carry_flag_out,      // Carry flag.
  output logic                                half_carry_flag_out, // Half-carry flag.
  output logic                                zero_flag_out,       // Zero flag.
  output logic                                nop_cycle_out,       // Flush cycle in progress.
  output logic                                prescaler_clear_out, // One-cycle clear pulse.
  output logic       [7:0]                    rmw_operand_out      // Read-modify-write operand.
);
  import lit_exec_pkg::*;

  // Execution state: normal issue or the discarded second cycle.
  typedef enum logic {
    ST_EXEC,
    ST_FLUSH
  } exec_state_t;

  exec_state_t  state_r, state_nxt;              // Execution state.
  logic [7:0]   acc_r, acc_nxt;                  // Accumulator.
  logic         carry_r, carry_nxt;              // Carry flag.
  logic         half_carry_flag_r, half_carry_flag_nxt; // Half-carry flag.
  logic         zero_r, zero_nxt;                // Zero flag.
  logic         psa_r, psa_nxt;                  // Prescaler assigned to timer zero.
  logic         nop_r, nop_nxt;                  // Registered flush indicator.
  logic         pclr_r, pclr_nxt;                // Registered prescaler clear pulse.
  logic [7:0]   rmw_r, rmw_nxt;                  // Registered read-modify-write operand.
  logic [7:0]   rdata_r, rdata_nxt;              // Registered read data.
  logic [7:0]   pin_meta_r, pin_meta_nxt;        // First synchroniser stage.
  logic [7:0]   pin_sync_r, pin_sync_nxt;        // Second synchroniser stage.

  logic         issue;       // An instruction executes this cycle.
  logic [5:0]   opc;         // Top six opcode bits.
  logic [6:0]   faddr;       // File address field.
  logic         file_write;  // Instruction writes its file operand.
  logic         is_port;     // File address is an I/O port.
  logic         counter_change; // Instruction needs a second cycle.

  lit_alu_if alu ();  // Datapath carrier.

  // Shared datapath for the four literal operations.
  lit_alu_core u_alu (
    .alu (alu.core)
  );

  // Field extraction and decoding of the current instruction.
  always_comb begin
    issue      = instr_valid_in && (state_r == ST_EXEC);
    opc        = instr_in[OPC_HI:OPC_LO];
    faddr      = instr_in[FADDR_HI:FADDR_LO];
    // Byte ops with the destination bit set, and bit clear or set, write the file.
    file_write = ((opc[5:4] == OPC_BYTE_GRP) && instr_in[DEST_BIT]) ||
                 (opc[5:3] == OPC_BITSET_GRP);
    is_port    = (faddr >= PORT_ADDR_FIRST) && (faddr <= PORT_ADDR_LAST);
    // Jumps and literal returns are known here; skips and counter writes arrive from outside.
    counter_change = program_counter_change_in;
    if (opc_match(opc, OPC_JUMP_PAT, OPC_JUMP_MASK)) begin
      counter_change = 1'b1;
    end
    // The literal return's accumulator load belongs to a neighbouring block.
    if (opc_match(opc, OPC_RETLIT_PAT, OPC_RETLIT_MASK)) begin
      counter_change = 1'b1;
    end
    alu.op      = issue ? decode_lit_op(opc) : OP_NONE;
    alu.literal = instr_in[LIT_HI:LIT_LO];
    alu.acc     = acc_r;
  end

  // Two-cycle sequencing for program-counter changes.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_EXEC: begin
        if (issue && counter_change) begin
          state_nxt = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        state_nxt = ST_EXEC;
      end
      default: begin
        state_nxt = ST_EXEC;
      end
    endcase
    nop_nxt = (state_nxt == ST_FLUSH);
  end

  // Accumulator and flags; a software write wins over execution in the same cycle.
  always_comb begin
    acc_nxt             = acc_r;
    carry_nxt           = carry_r;
    half_carry_flag_nxt = half_carry_flag_r;
    zero_nxt            = zero_r;
    psa_nxt             = psa_r;
    if (alu.op != OP_NONE) begin
      acc_nxt  = alu.result;
      zero_nxt = alu.zero;
      if (alu.arith) begin
        carry_nxt           = alu.carry;
        half_carry_flag_nxt = alu.half_carry;
      end
    end
    if (reg_wr_in) begin
      case (reg_addr_in)
        REG_ACCUM: acc_nxt = reg_wdata_in;
        REG_FLAGS: begin
          carry_nxt           = reg_wdata_in[FLAG_C_BIT];
          half_carry_flag_nxt = reg_wdata_in[FLAG_HALF_BIT];
          zero_nxt            = reg_wdata_in[FLAG_Z_BIT];
        end
        REG_CTRL:  psa_nxt = reg_wdata_in[CTRL_PSA_BIT];
        default:   psa_nxt = psa_r;  // Pin register and unmapped writes are ignored.
      endcase
    end
  end

  // Pin synchroniser, operand selection and prescaler clear.
  always_comb begin
    pin_meta_nxt = pin_in;
    pin_sync_nxt = pin_meta_r;
    rmw_nxt      = is_port ? pin_sync_r : file_data_in;
    pclr_nxt     = issue && file_write && (faddr == TIMER_ZERO_ADDR) && psa_r;
  end

  // Software read port; unmapped addresses read zero, data valid one cycle after the strobe.
  always_comb begin
    rdata_nxt = BYTE_ZERO;
    if (reg_rd_in) begin
      case (reg_addr_in)
        REG_ACCUM: rdata_nxt = acc_r;
        REG_FLAGS: begin
          rdata_nxt[FLAG_C_BIT]  = carry_r;
          rdata_nxt[FLAG_HALF_BIT] = half_carry_flag_r;
          rdata_nxt[FLAG_Z_BIT]  = zero_r;
        end
        REG_CTRL:  rdata_nxt[CTRL_PSA_BIT] = psa_r;
        REG_PINS:  rdata_nxt = pin_sync_r;
        default:   rdata_nxt = BYTE_ZERO;
      endcase
    end
  end

  // State registers; reset loads constants only.
  // Keeping logic off the reset path avoids glitches on an asynchronous assert.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r           <= ST_EXEC;
      acc_r             <= ACCUM_RST;
      carry_r           <= FLAG_RST;
      half_carry_flag_r <= FLAG_RST;
      zero_r            <= FLAG_RST;
      psa_r             <= PSA_RST;
      nop_r             <= 1'b0;
      pclr_r            <= 1'b0;
      rmw_r             <= BYTE_ZERO;
      rdata_r           <= BYTE_ZERO;
      pin_meta_r        <= BYTE_ZERO;
      pin_sync_r        <= BYTE_ZERO;
    end else begin
      state_r           <= state_nxt;
      acc_r             <= acc_nxt;
      carry_r           <= carry_nxt;
      half_carry_flag_r <= half_carry_flag_nxt;
      zero_r            <= zero_nxt;
      psa_r             <= psa_nxt;
      nop_r             <= nop_nxt;
      pclr_r            <= pclr_nxt;
      rmw_r             <= rmw_nxt;
      rdata_r           <= rdata_nxt;
      pin_meta_r        <= pin_meta_nxt;
      pin_sync_r        <= pin_sync_nxt;
    end
  end

  // Every output comes straight from a flip-flop.
  assign reg_rdata_out       = rdata_r;
  assign accumulator_out     = acc_r;
  assign carry_flag_out      = carry_r;
  assign half_carry_flag_out = half_carry_flag_r;
  assign zero_flag_out       = zero_r;
  assign nop_cycle_out       = nop_r;
  assign prescaler_clear_out = pclr_r;
  assign rmw_operand_out     = rmw_r;

endmodule
`default_nettype wire

// ### bench/lit_exec_chk.sv
// Port-level assertions for the literal execution block.
`timescale 1ns/1ps
`default_nettype none
module lit_exec_chk #(
  parameter logic [6:0] PORT_ADDR_FIRST = 7'h05,  // First port address.
  parameter logic [6:0] PORT_ADDR_LAST  = 7'h09   // Last port address.
) (
  input wire logic                               clock_in,
  input wire logic                               nrst_in,
  input wire logic                               instr_valid_in,
  input wire logic [lit_exec_pkg::INSTR_W-1:0]   instr_in,
  input wire logic [7:0]                         file_data_in,
  input wire logic [7:0]                         pin_in,
  input wire logic                               reg_wr_in,
  input wire logic [7:0]                         accumulator_out,
  input wire logic                               carry_flag_out,
  input wire logic                               half_carry_flag_out,
  input wire logic                               zero_flag_out,
  input wire logic                               nop_cycle_out,
  input wire logic                               prescaler_clear_out,
  input wire logic [7:0]                         rmw_operand_out
);
  import lit_exec_pkg::*;
  logic [7:0] lit;     // Literal field.
  logic [8:0] sum9;    // Add result with carry.
  logic [8:0] dif9;    // Subtract result, carry is no-borrow.
  logic [4:0] hs;      // Low nibble add.
  logic [4:0] hd;      // Low nibble subtract.
  logic       issue;   // Instruction really executes.
  logic       port;    // Operand address is a port.
  logic [1:0] up_r;    // Cycles since reset, saturating.
  logic [1:0] up_nxt;
  logic [7:0] xr;      // Exclusive OR of accumulator and literal.
  logic [7:0] ar;      // AND of accumulator and literal.
  assign lit   = instr_in[7:0];
  assign sum9  = {1'b0, accumulator_out} + {1'b0, lit};
  assign dif9  = {1'b0, lit} + {1'b0, ~accumulator_out} + 9'h001;
  assign hs    = {1'b0, accumulator_out[3:0]} + {1'b0, lit[3:0]};
  assign hd    = {1'b0, lit[3:0]} + {1'b0, ~accumulator_out[3:0]} + 5'h01;
  assign issue = instr_valid_in && !nop_cycle_out && !reg_wr_in;
  assign xr    = accumulator_out ^ lit;
  assign ar    = accumulator_out & lit;
  assign port  = instr_in[6:0] >= PORT_ADDR_FIRST && instr_in[6:0] <= PORT_ADDR_LAST;
  // The synchroniser holds stale zeros just after reset, so pin checks wait.
  always_comb begin
    up_nxt = (up_r == 2'h3) ? up_r : up_r + 2'h1;
  end
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      up_r <= 2'h0;
    end else begin
      up_r <= up_nxt;
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  chk_add_value: assert property (issue && instr_in[13:9] == 5'h1F |=>
    accumulator_out == $past(sum9[7:0])) else $error("add result wrong");
  chk_add_carry: assert property (issue && instr_in[13:9] == 5'h1F |=>
    carry_flag_out == $past(sum9[8]) && half_carry_flag_out == $past(hs[4]))
    else $error("add carries wrong");
  chk_sub_value: assert property (issue && instr_in[13:9] == 5'h1E |=>
    accumulator_out == $past(dif9[7:0]) && carry_flag_out == $past(dif9[8])
    && half_carry_flag_out == $past(hd[4])) else $error("subtract wrong");
  chk_xor_flags: assert property (issue && instr_in[13:8] == 6'h3A |=>
    accumulator_out == $past(xr) && $stable(carry_flag_out)
    && $stable(half_carry_flag_out)) else $error("xor wrong");
  chk_and_value: assert property (issue && instr_in[13:8] == 6'h39 |=>
    accumulator_out == $past(ar) && $stable(carry_flag_out))
    else $error("and wrong");
  chk_zero_track: assert property (issue && instr_in[13:11] == 3'h7
    && instr_in[10:8] != 3'h0 && instr_in[10:8] != 3'h3
    |=> zero_flag_out == (accumulator_out == 8'h00)) else $error("zero flag wrong");
  chk_flush_raise: assert property (issue && instr_in[13:12] == 2'h2 |=>
    nop_cycle_out) else $error("no flush after jump");
  chk_flush_quiet: assert property (nop_cycle_out && !reg_wr_in |=>
    $stable(accumulator_out) && $stable(zero_flag_out) && !nop_cycle_out
    && !prescaler_clear_out) else $error("flush cycle had effect");
  chk_pin_operand: assert property (up_r == 2'h3 && port && $stable(pin_in)
    && $past(pin_in, 2) == pin_in |=> rmw_operand_out == $past(pin_in))
    else $error("port operand not from pins");
  chk_file_operand: assert property (!port |=>
    rmw_operand_out == $past(file_data_in)) else $error("file operand wrong");
  cov_add: cover property (issue && instr_in[13:9] == 5'h1F);
  cov_flush: cover property (nop_cycle_out);
  cov_clear: cover property (prescaler_clear_out);
endmodule
bind literal_alu_instruction_exec lit_exec_chk #(
  .PORT_ADDR_FIRST(PORT_ADDR_FIRST),
  .PORT_ADDR_LAST(PORT_ADDR_LAST)
) chk (.*);
`default_nettype wire

// ### bench/reg_file_model.sv
// Register file stand-in: read data is a fixed function of the address.
`timescale 1ns/1ps
`default_nettype none
module reg_file_model (
  input  wire logic [6:0] addr_in,   // File address being read.
  output logic      [7:0] data_out   // Read data, same cycle.
);
  // Every address gives a distinct byte, so a wrong address shows up.
  assign data_out = {1'b0, addr_in} ^ 8'hA5;
endmodule
`default_nettype wire

// ### bench/literal_alu_instruction_exec_tb_top.sv
// Self-checking testbench for the literal execution block.
`timescale 1ns/1ps
`default_nettype none
module literal_alu_instruction_exec_tb_top;
  logic clock_in = 1'b0, nrst_in = 1'b0, instr_valid_in = 1'b0;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, program_counter_change_in = 1'b0;
  logic [13:0] instr_in = 14'h0000;
  logic [7:0] pin_in = 8'h00, reg_addr_in = 8'h00, reg_wdata_in = 8'h00, file_data_in;
  logic [7:0] reg_rdata_out, accumulator_out, rmw_operand_out;
  logic carry_flag_out, half_carry_flag_out, zero_flag_out, nop_cycle_out, prescaler_clear_out;
  int miscompares = 0, check_count = 0, cyc = 0;
  literal_alu_instruction_exec uut (.clock_in(clock_in), .nrst_in(nrst_in),
    .instr_valid_in(instr_valid_in), .instr_in(instr_in),
    .program_counter_change_in(program_counter_change_in),
    .file_data_in(file_data_in), .pin_in(pin_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .accumulator_out(accumulator_out),
    .carry_flag_out(carry_flag_out), .half_carry_flag_out(half_carry_flag_out),
    .zero_flag_out(zero_flag_out), .nop_cycle_out(nop_cycle_out),
    .prescaler_clear_out(prescaler_clear_out), .rmw_operand_out(rmw_operand_out));
  reg_file_model rf (.addr_in(instr_in[6:0]), .data_out(file_data_in));
  initial begin
    forever #2.5 clock_in = ~clock_in;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // The whole run needs under a hundred cycles; a hang ends here.
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1 check(reg_rdata_out, exp);
  endtask
  task automatic exec(input logic [13:0] w);
    @(posedge clock_in);
    instr_valid_in <= 1'b1;
    instr_in <= w;
    @(posedge clock_in);
    instr_valid_in <= 1'b0;
    #1;
  endtask
  function automatic logic [7:0] flg();
    return {5'h00, zero_flag_out, half_carry_flag_out, carry_flag_out};
  endfunction
  // Both don't-care settings of the add and subtract opcodes, with carries.
  task automatic t_arith();
    wr(8'h00, 8'h10);
    exec(14'h3E15);
    check(accumulator_out, 8'h25);
    check(flg(), 8'h00);
    wr(8'h00, 8'hFF);
    exec(14'h3F01);
    check(flg(), 8'h07);
    rd(8'h00, 8'h00);
    wr(8'h00, 8'h06);
    exec(14'h3C05);
    check(accumulator_out, 8'hFF);
    check(flg(), 8'h00);
    wr(8'h00, 8'h10);
    exec(14'h3D10);
    check(accumulator_out, 8'h00);
    check(flg(), 8'h07);
  endtask
  // Logic ops leave carry and half carry as they were.
  task automatic t_logic();
    wr(8'h04, 8'h03);
    wr(8'h00, 8'hA3);
    exec(14'h395F);
    check(accumulator_out, 8'h03);
    check(flg(), 8'h03);
    exec(14'h3A03);
    check(accumulator_out, 8'h00);
    check(flg(), 8'h07);
  endtask
  // A jump, a literal return and a true test each discard one following instruction.
  task automatic t_flush(input logic [13:0] w, input logic chg);
    wr(8'h00, 8'h10);
    @(posedge clock_in);
    instr_valid_in <= 1'b1;
    instr_in <= w;
    program_counter_change_in <= chg;
    @(posedge clock_in);
    instr_in <= 14'h3E15;
    program_counter_change_in <= 1'b0;
    #1 check({7'h00, nop_cycle_out}, 8'h01);
    @(posedge clock_in);
    instr_valid_in <= 1'b0;
    #1 check({7'h00, nop_cycle_out}, 8'h00);
    check(accumulator_out, 8'h10);
    check(flg(), 8'h07);
  endtask
  // The clear follows a timer write only while the prescaler is assigned.
  task automatic t_presc();
    wr(8'h08, 8'h00);
    exec(14'h0081);
    check({7'h00, prescaler_clear_out}, 8'h00);
    wr(8'h08, 8'h01);
    rd(8'h08, 8'h01);
    exec(14'h0081);
    check({7'h00, prescaler_clear_out}, 8'h01);
    exec(14'h0001);
    check({7'h00, prescaler_clear_out}, 8'h00);
    exec(14'h1081);
    check({7'h00, prescaler_clear_out}, 8'h01);
  endtask
  // Port operands come from the pins, other addresses from the file.
  task automatic t_pins();
    @(posedge clock_in);
    instr_in <= 14'h0005;
    pin_in <= 8'h3C;
    repeat (4) @(posedge clock_in);
    #1 check(rmw_operand_out, 8'h3C);
    rd(8'h0C, 8'h3C);
    @(posedge clock_in);
    instr_in <= 14'h0020;
    @(posedge clock_in);
    #1 check(rmw_operand_out, 8'h85);
    rd(8'h10, 8'h00);
  endtask
  initial begin
    repeat (4) @(posedge clock_in);
    nrst_in <= 1'b1;
    t_arith();
    t_logic();
    t_flush(14'h2800, 1'b0);
    t_flush(14'h0100, 1'b1);
    t_flush(14'h3400, 1'b0);
    t_presc();
    t_pins();
    summarize();
  end
endmodule
`default_nettype wire
